/* core/pch_config_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (RQ1) Read-only byte at 0x57 reports worst-case power, zero after reset.
// (RQ2) Select 0..7 gives state D0..D7 power in 40*scale watts; 8..15 give zero.
// (RQ3) Sixteen-bit read/write device identifier at offset 0x02, word access.
// (RQ4) Thirty-two-bit expansion ROM base at 0x30, resets to zero, dword access.
// (RQ5) With the ROM decode enable clear, no expansion ROM access is claimed.
// (RQ6) ROM decoded only while decode enable and memory space enable both set.
// (RQ7) Software writes reserved ROM base bits as zero and ignores them on read.
// (RQ8) Size select zero: all seventeen base bits from 15 upward are valid.
// (RQ9) Size select one: only bits 31..16 used, bit 15 forced zero on writes.
// (RQ10) Header layout code is read-only and returns 0x00.
// (RQ11) ROM decoding additionally needs the D0 power state.
module pch_config_regs
  import pch_pkg::*;
#(
  // Arbitrary neutral identifier value
  parameter logic [15:0] DEVICE_ID_RESET = 16'h5A3C,
  parameter logic [8*PCH_PWR_DEPTH-1:0] POWER_TABLE = 64'h0000_0000_0000_0000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic memory_space_enable,
  input wire logic rom_size_select,
  input wire logic [1:0] power_state,
  input wire logic [PCH_SEL_W-1:0] power_data_select,
  input wire logic [1:0] power_data_scale,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic rom_decode_active,
  output logic rom_claim
);

  logic [15:0] device_identifier;
  logic rom_decode_enable;
  logic [PCH_ROM_FIELD_W-1:0] rom_window_base;
  logic [7:0] power_report;
  logic [7:0] header_layout_code;
  logic [7:0] table_data;
  logic [31:0] next_rdata;
  logic [31:0] rom_base_value;
  logic [15:0] next_device_identifier;
  logic [PCH_ROM_FIELD_W-1:0] next_rom_window_base;
  logic next_rom_decode_enable;
  logic hit_id, hit_layout, hit_rom, hit_power;
  logic wr_id, wr_rom;
  logic window_match;

  function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] off);
    dword_hit = (addr[7:2] == off[7:2]);
  endfunction

  assign hit_id = dword_hit(cfg_addr, PCH_OFF_DEVICE_ID);
  assign hit_layout = dword_hit(cfg_addr, PCH_OFF_HEADER_LAYOUT);
  assign hit_rom = dword_hit(cfg_addr, PCH_OFF_ROM_BASE);
  assign hit_power = dword_hit(cfg_addr, PCH_OFF_POWER_REPORT);
  assign wr_id = cfg_wr && hit_id;
  assign wr_rom = cfg_wr && hit_rom;

  assign header_layout_code = PCH_HEADER_LAYOUT_VALUE; // RQ10

  // Device identifier sits in the upper half of the first dword
  assign next_device_identifier[7:0] = cfg_be[2] ? cfg_wdata[23:16] : device_identifier[7:0]; // RQ3
  assign next_device_identifier[15:8] = cfg_be[3] ? cfg_wdata[31:24] : device_identifier[15:8]; // RQ3

  // Reserved bits 14..1 are never stored, so they always read back zero
  assign next_rom_decode_enable = cfg_be[0] ? cfg_wdata[PCH_ROM_EN_BIT] : rom_decode_enable;
  assign next_rom_window_base[0] = !cfg_be[1] ? rom_window_base[0] :
                                   rom_size_select ? 1'b0 : cfg_wdata[PCH_ROM_BASE_LSB]; // RQ8 RQ9
  assign next_rom_window_base[8:1] = cfg_be[2] ? cfg_wdata[23:16] : rom_window_base[8:1];
  assign next_rom_window_base[16:9] = cfg_be[3] ? cfg_wdata[31:24] : rom_window_base[16:9];

  assign rom_base_value = {rom_window_base, 14'h0000, rom_decode_enable};

  // Size one ignores bit 15 so a 64 KB window decodes even if it was set earlier
  assign window_match = rom_size_select ?
    (mem_addr[PCH_ROM_BASE_MSB:PCH_ROM_BASE_LSB+1] == rom_window_base[PCH_ROM_FIELD_W-1:1]) :
    (mem_addr[PCH_ROM_BASE_MSB:PCH_ROM_BASE_LSB] == rom_window_base); // RQ8 RQ9
  assign rom_decode_active = rom_decode_enable && memory_space_enable &&
                             (power_state == PCH_POWER_STATE_D0); // RQ5 RQ6 RQ11
  assign rom_claim = rom_decode_active && mem_req && window_match; // RQ5 RQ6 RQ11

  assign next_rdata = hit_id ? {device_identifier, 16'h0000} :
                      hit_layout ? {8'h00, header_layout_code, 16'h0000} :
                      hit_rom ? rom_base_value :
                      hit_power ? {power_report, 24'h000000} : 32'h0000_0000;

  // Scale is a read-side interpretation factor; the table holds raw units
  pch_power_table #(
    .DEPTH(PCH_PWR_DEPTH),
    .TABLE(POWER_TABLE)
  ) u_power_table (
    .core_clk(core_clk),
    .rst(rst),
    .sel(power_data_select),
    .rd_data(table_data)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      device_identifier <= DEVICE_ID_RESET;
    end else if (wr_id) begin
      device_identifier <= next_device_identifier; // RQ3
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rom_decode_enable <= PCH_ROM_BASE_RESET[PCH_ROM_EN_BIT]; // RQ4
      rom_window_base <= PCH_ROM_BASE_RESET[PCH_ROM_BASE_MSB:PCH_ROM_BASE_LSB]; // RQ4
    end else if (wr_rom) begin
      rom_decode_enable <= next_rom_decode_enable;
      rom_window_base <= next_rom_window_base;
    end
  end

  // No write path reaches the power report
  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_report <= PCH_POWER_REPORT_RESET; // RQ1
    end else begin
      power_report <= table_data; // RQ1 RQ2
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rdata <= cfg_rd ? next_rdata : 32'h0000_0000;
      cfg_rvalid <= cfg_rd;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_report_reads_back: assert property (cfg_rd && hit_power |=> // RQ1
    cfg_rdata[31:24] == $past(power_report))
    else $error("power report byte read wrong");

  a_report_reset_zero: assert property (@(posedge core_clk) disable iff (1'b0) rst |=> // RQ1
    power_report == PCH_POWER_REPORT_RESET)
    else $error("power report not zero after reset");

  a_report_reserved_zero: assert property (power_data_select >= 4'h8 ##1 !rst |-> // RQ2
    ##1 power_report == 8'h00)
    else $error("reserved select did not read zero");

  a_report_follows_table: assert property (1'b1 |=> // RQ2
    power_report == $past(table_data))
    else $error("power report does not follow table");

  a_ident_write: assert property (wr_id && cfg_be[3] && cfg_be[2] |=> // RQ3
    device_identifier == $past(cfg_wdata[31:16]))
    else $error("device identifier write lost");

  a_ident_reset_value: assert property (@(posedge core_clk) disable iff (1'b0) rst |=> // RQ3
    device_identifier == DEVICE_ID_RESET)
    else $error("device identifier reset value wrong");

  a_ident_held: assert property (!wr_id |=> // RQ3
    $stable(device_identifier))
    else $error("device identifier changed without write");

  a_ident_reads_back: assert property (cfg_rd && hit_id |=> // RQ3
    cfg_rdata == {$past(device_identifier), 16'h0000})
    else $error("device identifier read wrong");

  a_rom_reset_zero: assert property (@(posedge core_clk) disable iff (1'b0) rst |=> // RQ4
    rom_base_value == 32'h0000_0000)
    else $error("rom base not zero after reset");

  a_rom_held: assert property (!wr_rom |=> // RQ4
    $stable(rom_base_value))
    else $error("rom base changed without write");

  a_rom_reads_back: assert property (cfg_rd && hit_rom |=> // RQ4
    cfg_rdata == $past(rom_base_value))
    else $error("rom base read wrong");

  a_rom_disabled_quiet: assert property (!rom_decode_enable |-> // RQ5
    !rom_claim && !rom_decode_active)
    else $error("rom claimed while decode disabled");

  a_rom_needs_both: assert property (rom_claim |-> // RQ6
    rom_decode_enable && memory_space_enable && mem_req)
    else $error("rom claimed without both enables");

  a_rom_active_full: assert property (rom_decode_enable && memory_space_enable && // RQ6
    power_state == PCH_POWER_STATE_D0 |-> rom_decode_active)
    else $error("rom decode inactive with all enables set");

  a_base_bit15_kept: assert property (wr_rom && cfg_be[1] && !rom_size_select |=> // RQ8
    rom_base_value[15] == $past(cfg_wdata[15]))
    else $error("bit 15 not stored with size select zero");

  a_claim_size_zero: assert property (rom_claim && !rom_size_select |-> // RQ8
    mem_addr[PCH_ROM_BASE_MSB:PCH_ROM_BASE_LSB] == rom_window_base)
    else $error("rom claimed outside small window");

  a_base_bit15_forced: assert property (wr_rom && cfg_be[1] && rom_size_select |=> // RQ9
    rom_base_value[15] == 1'b0)
    else $error("bit 15 not forced zero");

  a_claim_size_one: assert property (rom_claim && rom_size_select |-> // RQ9
    mem_addr[PCH_ROM_BASE_MSB:PCH_ROM_BASE_LSB+1] == rom_window_base[PCH_ROM_FIELD_W-1:1])
    else $error("rom claimed outside large window");

  a_layout_zero: assert property (cfg_rd && hit_layout |=> // RQ10
    cfg_rvalid && cfg_rdata[23:16] == 8'h00)
    else $error("header layout code not zero");

  a_rom_needs_d0: assert property (power_state != PCH_POWER_STATE_D0 |-> // RQ11
    !rom_claim)
    else $error("rom claimed outside D0");

endmodule

/* core/pch_pkg.sv */
package pch_pkg;

  // Byte offsets inside the configuration header
  localparam logic [7:0] PCH_OFF_DEVICE_ID = 8'h02;
  localparam logic [7:0] PCH_OFF_HEADER_LAYOUT = 8'h0E;
  localparam logic [7:0] PCH_OFF_ROM_BASE = 8'h30;
  localparam logic [7:0] PCH_OFF_POWER_REPORT = 8'h57;

  // Field positions
  localparam int PCH_ROM_EN_BIT = 0;
  localparam int PCH_ROM_BASE_LSB = 15;
  localparam int PCH_ROM_BASE_MSB = 31;
  localparam int PCH_ROM_FIELD_W = PCH_ROM_BASE_MSB - PCH_ROM_BASE_LSB + 1;

  // Reset and fixed values
  localparam logic [31:0] PCH_ROM_BASE_RESET = 32'h0000_0000;
  localparam logic [7:0] PCH_POWER_REPORT_RESET = 8'h00;
  localparam logic [7:0] PCH_HEADER_LAYOUT_VALUE = 8'h00;
  localparam logic [1:0] PCH_POWER_STATE_D0 = 2'h0;

  // Power report selection
  localparam int PCH_SEL_W = 4;
  localparam int PCH_PWR_DEPTH = 8;

endpackage

/* core/pch_power_table.sv */
`timescale 1ns/1ps
module pch_power_table
  import pch_pkg::*;
#(
  parameter int DEPTH = PCH_PWR_DEPTH,
  parameter logic [8*PCH_PWR_DEPTH-1:0] TABLE = 64'h0000_0000_0000_0000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [PCH_SEL_W-1:0] sel,
  output logic [7:0] rd_data
);

  logic [7:0] entry [DEPTH];
  logic in_range;
  logic [7:0] next_rd_data;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      assign entry[g] = TABLE[8*g +: 8];
    end
  endgenerate

  // Codes past the populated states are reserved and read as zero
  assign in_range = (32'(sel) < 32'(DEPTH));
  assign next_rd_data = in_range ? entry[sel[2:0]] : 8'h00;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

/* tb/pch_host_model.sv */
`timescale 1ns/1ps
module pch_host_model (
  input wire logic core_clk,
  output logic mem_req,
  output logic [31:0] mem_addr
);
  initial begin
    mem_req = 1'b0;
    mem_addr = 32'h0000_0000;
  end
  task automatic drive(input logic [31:0] a);
    @(posedge core_clk);
    mem_req <= 1'b1;
    mem_addr <= a;
  endtask
  // Released bus shows the inverse, so a stale address cannot pass for a live one
  task automatic release_bus();
    @(posedge core_clk);
    mem_req <= 1'b0;
    mem_addr <= ~mem_addr;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pch_pkg::*;
  localparam logic [63:0] PTAB = 64'h8877_6655_4433_2211;
  logic core_clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, memory_space_enable = 0, rom_size_select = 0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0, power_data_select = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, mem_addr;
  logic [1:0] power_state = 2'h0;
  logic cfg_rvalid, mem_req, rom_decode_active, rom_claim;
  int n_mismatch = 0, tests_run = 0;
  always #25 core_clk = ~core_clk;
  pch_host_model host (.core_clk(core_clk), .mem_req(mem_req), .mem_addr(mem_addr));
  pch_config_regs #(.DEVICE_ID_RESET(16'h3C5A), .POWER_TABLE(PTAB)) dut (
    .core_clk(core_clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .memory_space_enable(memory_space_enable), .rom_size_select(rom_size_select),
    .power_state(power_state), .power_data_select(power_data_select), .power_data_scale(2'h1),
    .mem_req(mem_req), .mem_addr(mem_addr), .rom_decode_active(rom_decode_active), .rom_claim(rom_claim));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge core_clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, be, d};
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    #1 chk(cfg_rvalid === 1'b1 ? cfg_rdata : ~exp, exp);
  endtask
  task automatic claim(input logic [31:0] a, input logic e);
    host.drive(a);
    #1 chk({31'h0, rom_claim}, {31'h0, e});
    host.release_bus();
  endtask
  task automatic complete_run();
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h54, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h00, 32'h3C5A_0000);
    wr(8'h00, 4'hC, 32'hBEEF_0000);
    rd(8'h00, 32'hBEEF_0000);
    $display("test reset and identifier done");
    wr(8'h30, 4'hF, 32'h1234_8001);
    rd(8'h30, 32'h1234_8001);
    @(posedge core_clk) rom_size_select <= 1'b1;
    wr(8'h30, 4'hF, 32'hABCD_8001);
    rd(8'h30, 32'hABCD_0001);
    $display("test rom base done");
    @(posedge core_clk) memory_space_enable <= 1'b1;
    claim(32'hABCD_F234, 1'b1);
    claim(32'hABCE_0000, 1'b0);
    @(posedge core_clk) power_state <= 2'h3;
    claim(32'hABCD_1234, 1'b0);
    @(posedge core_clk) {power_state, memory_space_enable} <= 3'b000;
    claim(32'hABCD_1234, 1'b0);
    @(posedge core_clk) memory_space_enable <= 1'b1;
    wr(8'h30, 4'h1, 32'h0);
    claim(32'hABCD_1234, 1'b0);
    @(posedge core_clk) rom_size_select <= 1'b0;
    wr(8'h30, 4'h1, 32'h0000_0001);
    claim(32'hABCD_8000, 1'b0);
    claim(32'hABCD_7FFC, 1'b1);
    $display("test rom decode done");
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk) power_data_select <= i[3:0];
      repeat (2) @(posedge core_clk);
      rd(8'h54, {(i < 8) ? PTAB[8*i +: 8] : 8'h00, 24'h0});
    end
    wr(8'h54, 4'h8, 32'hFF00_0000);
    rd(8'h54, 32'h0);
    $display("test power report done");
    @(posedge core_clk) {rst, power_data_select} <= {1'b1, 4'h0};
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h54, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h00, 32'h3C5A_0000);
    rd(8'h54, {PTAB[7:0], 24'h0});
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
